//--- bench/rcf_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host parser on the serial side: takes bytes, checks framing, counts frames
module rcf_host_model
  import rcf_pkg::*;
(
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst,
  input  wire logic         i_slow,
  input  wire rcf_byte_type i_tx,
  output logic              o_tx_ready,
  output logic [7:0]        o_frame [0:39],
  output int                o_len,
  output int                o_frames,
  output int                o_bad
);
  logic [1:0] phase;
  int         idx;
  logic [7:0] sum;

  // Slow mode takes one byte in four, so every byte must stand for a while
  assign o_tx_ready = !i_slow || (phase == 2'b00);

  // Gather bytes; judge length and checksum when the last byte arrives
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      phase <= 2'b00;
      idx = 0;
      o_frames <= 0;
      o_bad <= 0;
      o_len <= 0;
    end else begin
      phase <= phase + 2'b01;
      if (i_tx.valid && o_tx_ready) begin
        // Bytes ahead of a delimiter are skipped so the parser resyncs
        if ((idx != 0 || i_tx.data == RCF_DELIM) && idx < 40) begin
          o_frame[idx] = i_tx.data;
          idx = idx + 1;
        end
        if (i_tx.last) begin
          sum = 8'h00;
          for (int k = 3; k < idx; k++) sum = sum + o_frame[k];
          // Reserved bytes are not judged and repeated ids are welcome
          if (idx > 4 && sum == RCF_CSUM_BASE && {o_frame[1], o_frame[2]} == 16'(idx - 4)) begin
            o_frames <= o_frames + 1;
            o_len <= idx;
          end else begin
            o_bad <= o_bad + 1;
          end
          idx = 0;
        end
      end
    end
  end
endmodule

`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import rcf_pkg::*;

  typedef struct packed {
    logic [7:0]  fid;
    logic [15:0] cmd;
    logic [7:0]  status;
    logic        q;
    logic [4:0]  plen;
    logic        slow;
  } rcf_row_type;

  logic         i_sys_clk = 1'b0;
  logic         i_rst;
  logic         i_req_valid;
  logic         o_req_ready;
  rcf_req_type  i_req;
  logic         i_pw_en;
  logic [3:0]   i_pw_addr;
  logic [7:0]   i_pw_data;
  rcf_byte_type o_tx;
  logic         i_tx_ready;
  logic         o_dropped;
  logic         slow;
  logic [7:0]   frame [0:39];
  int           f_len;
  int           frames;
  int           bad;
  int           fail_count = 0;
  int           n_checks = 0;
  int           cyc = 0;
  logic [7:0]   exp [0:39];
  int           exp_n;
  logic         dropped;
  rcf_row_type  rows [0:7] = '{
    '{8'h27, 16'h4E49, 8'h00, 1'b0, 5'h00, 1'b0},
    '{8'h27, 16'h4944, 8'h04, 1'b0, 5'h00, 1'b1},
    '{8'h27, 16'h5450, 8'h00, 1'b1, 5'h02, 1'b0},
    '{8'h01, 16'h4142, 8'h01, 1'b0, 5'h00, 1'b0},
    '{8'hFF, 16'h4344, 8'h02, 1'b0, 5'h09, 1'b1},
    '{8'h80, 16'h4546, 8'h03, 1'b1, 5'h01, 1'b0},
    '{8'h55, 16'h4748, 8'h0C, 1'b1, 5'h10, 1'b1},
    '{8'h12, 16'h4A4B, 8'h00, 1'b1, 5'h11, 1'b0}
  };

  // Clock at 25 MHz
  always #20 i_sys_clk = ~i_sys_clk;

  rcf_framer dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req(i_req), .i_pw_en(i_pw_en), .i_pw_addr(i_pw_addr),
    .i_pw_data(i_pw_data), .o_tx(o_tx), .i_tx_ready(i_tx_ready), .o_dropped(o_dropped));

  rcf_host_model host (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_slow(slow), .i_tx(o_tx),
    .o_tx_ready(i_tx_ready), .o_frame(frame), .o_len(f_len), .o_frames(frames), .o_bad(bad));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", what, e, g);
      fail_count++;
    end
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Request held from a falling edge until the edge that takes it
  task automatic offer(input rcf_row_type r, input logic [7:0] typ);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    i_req = '{typ, r.fid, 64'h0011_2233_4455_6677 ^ {8{r.fid}}, r.cmd, r.status, r.q, r.plen};
    i_req_valid = 1'b1;
    while (o_req_ready !== 1'b1 && n < 2000) begin
      @(negedge i_sys_clk);
      n++;
    end
    @(negedge i_sys_clk);
    dropped = o_dropped;
    i_req_valid = 1'b0;
  endtask

  // Expected frame worked out from the field layout
  task automatic run_row(input rcf_row_type r);
    int n;
    int k;
    int f0;
    logic [7:0] s;
    logic [63:0] a;
    n = (r.q && r.plen <= 5'h10) ? int'(r.plen) : 0;
    a = 64'h0011_2233_4455_6677 ^ {8{r.fid}};
    exp[0] = RCF_DELIM;
    exp[1] = 8'h00;
    exp[2] = 8'(15 + n);
    exp[3] = RCF_TYPE_RESP;
    exp[4] = r.fid;
    for (k = 0; k < 8; k++) exp[5 + k] = a[63 - 8 * k -: 8];
    exp[13] = 8'hFF;
    exp[14] = 8'hFE;
    exp[15] = r.cmd[15:8];
    exp[16] = r.cmd[7:0];
    exp[17] = r.status;
    for (k = 0; k < n; k++) exp[18 + k] = 8'hA0 + 8'(k);
    s = 8'h00;
    for (k = 3; k < 18 + n; k++) s = s + exp[k];
    exp[18 + n] = 8'hFF - s;
    exp_n = 19 + n;
    slow = r.slow;
    f0 = frames;
    offer(r, RCF_TYPE_REQ);
    chk("dropped flag", 8'h00, {7'h00, dropped});
    k = 0;
    while (frames == f0 && k < 1000) begin
      @(negedge i_sys_clk);
      k++;
    end
    chk("frame seen", 8'h01, {7'h00, frames != f0});
    chk("frame length", 8'(exp_n), 8'(f_len));
    for (k = 0; k < exp_n; k++) chk("frame byte", exp[k], frame[k]);
  endtask

  // Hang guard
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up;
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    i_req_valid = 1'b0;
    i_req = '0;
    i_pw_en = 1'b0;
    i_pw_addr = 4'h0;
    i_pw_data = 8'h00;
    slow = 1'b0;
    repeat (12) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk("ready in reset", 8'h01, {7'h00, o_req_ready});
    chk("valid in reset", 8'h00, {7'h00, o_tx.valid});
    chk("drop in reset", 8'h00, {7'h00, o_dropped});
    i_rst = 1'b0;
    // Value bytes loaded before any frame so no write lands mid-frame
    for (int i = 0; i < 16; i++) begin
      @(negedge i_sys_clk);
      i_pw_en = 1'b1;
      i_pw_addr = 4'(i);
      i_pw_data = 8'hA0 + 8'(i);
    end
    @(negedge i_sys_clk);
    i_pw_en = 1'b0;
    for (int r = 0; r < 8; r++) run_row(rows[r]);
    // Zero identifier and a foreign request type give no frame
    offer('{8'h00, 16'h4E49, 8'h00, 1'b0, 5'h00, 1'b0}, RCF_TYPE_REQ);
    chk("zero id drop", 8'h01, {7'h00, dropped});
    offer('{8'h33, 16'h4E49, 8'h00, 1'b0, 5'h00, 1'b0}, 8'h18);
    chk("foreign type drop", 8'h01, {7'h00, dropped});
    repeat (40) @(negedge i_sys_clk);
    chk("frame count", 8'd8, 8'(frames));
    chk("bad frames", 8'h00, 8'(bad));
    wrap_up;
  end
endmodule

`default_nettype wire

//--- hdl/rcf_csum.sv
`timescale 1ns/1ps
`default_nettype none

// Running checksum over the bytes between length and checksum
module rcf_csum
  import rcf_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_clear,
  input  wire logic       i_add,
  input  wire logic [7:0] i_byte,
  output logic      [7:0] o_csum
);

  logic [7:0] sum;

  // ---------------------------------------------------------------
  // Low eight bits of the sum, wrap is intended
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sum <= 8'h00;
    end else if (i_clear) begin
      sum <= 8'h00;
    end else if (i_add) begin
      sum <= sum + i_byte;
    end
  end

  assign o_csum = RCF_CSUM_BASE - sum;

endmodule

`default_nettype wire

//--- hdl/rcf_framer.sv
// Function
// - Handled request of type 0x17 yields response frame of type 0x97.
// - No response frame when the request frame identifier is zero.
// - Several responses per request allowed; host accepts repeated identifiers.
// - Frame opens with one delimiter byte at position 0.
// - Two-byte length at position 1 counts bytes between length and checksum.
// - Request frame identifier copied to position 4.
// - Eight-byte responder address starts at position 5.
// - Positions 13 and 14 carry 0xFFFE; host ignores them.
// - Two command characters echoed from position 15, request order.
// - Status byte at position 17 with the listed codes.
// - Parameter field omitted after a set; checksum follows status.
// - Query appends current value bytes after the status byte; none if param_len exceeds 16.
// - Checksum is 0xFF minus low byte of sum from position 3.
`timescale 1ns/1ps
`default_nettype none

module rcf_framer
  import rcf_pkg::*;
#(
  parameter int PARAM_MAX = RCF_PARAM_MAX
) (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_req_valid,
  output logic                              o_req_ready,
  input  wire rcf_req_type                  i_req,
  input  wire logic                         i_pw_en,
  input  wire logic [$clog2(PARAM_MAX)-1:0] i_pw_addr,
  input  wire logic [7:0]                   i_pw_data,
  output rcf_byte_type                      o_tx,
  input  wire logic                         i_tx_ready,
  output logic                              o_dropped
);

  localparam int AW = $clog2(PARAM_MAX);

  typedef enum logic [1:0] {
    RCF_IDLE,
    RCF_SEND
  } rcf_state_type;

  rcf_state_type state;
  rcf_req_type   req;
  logic [5:0]    pos;
  logic [4:0]    pidx;
  logic [7:0]    pbyte;
  logic [7:0]    csum;

  // ---------------------------------------------------------------
  // Request acceptance
  // ---------------------------------------------------------------
  wire logic       is_req     = (i_req.req_type == RCF_TYPE_REQ);
  wire logic       want_frame = is_req && (i_req.frame_id != 8'h00);
  wire logic       plen_ok    = i_req.param_len <= 5'(PARAM_MAX);
  wire logic       take       = i_req_valid && (state == RCF_IDLE);
  wire logic [4:0] plen_eff   = i_req.is_query && plen_ok ? i_req.param_len
                                                         : 5'd0;
  wire logic       has_param  = (req.param_len != 5'd0);
  wire logic [15:0] frame_len = RCF_LEN_FIXED + {11'd0, req.param_len};
  // Six bits: a full sixteen-byte value puts the checksum at position 34
  wire logic [5:0] last_pos   = 6'(RCF_POS_PARAM) + {1'b0, req.param_len};
  wire logic       in_param   = has_param && (pos >= 6'(RCF_POS_PARAM))
                                && (pos < last_pos);
  wire logic       step       = (state == RCF_SEND) && i_tx_ready;
  wire logic       in_sum     = (pos >= 6'(RCF_POS_TYPE)) && (pos < last_pos);
  wire logic [2:0] addr_idx   = 3'(pos - 6'(RCF_POS_ADDR));

  // Idle again after each frame, so a repeated identifier is simply served again
  assign o_req_ready = (state == RCF_IDLE);

  // ---------------------------------------------------------------
  // Byte selection by position
  // ---------------------------------------------------------------
  logic [7:0] next_byte;
  always_comb begin
    next_byte = 8'h00;
    case (pos)
      6'd0:    next_byte = RCF_DELIM;
      6'd1:    next_byte = frame_len[15:8];
      6'd2:    next_byte = frame_len[7:0];
      6'd3:    next_byte = RCF_TYPE_RESP;
      6'd4:    next_byte = req.frame_id;
      6'd5, 6'd6, 6'd7, 6'd8, 6'd9, 6'd10, 6'd11, 6'd12:
               next_byte = req.addr[8*(7-addr_idx) +: 8];
      6'd13:   next_byte = RCF_RESERVED[15:8];
      6'd14:   next_byte = RCF_RESERVED[7:0];
      6'd15:   next_byte = req.cmd[15:8];
      6'd16:   next_byte = req.cmd[7:0];
      6'd17:   next_byte = req.status;
      default: begin
        if (in_param) begin
          next_byte = pbyte;
        end else begin
          next_byte = csum;
        end
      end
    endcase
  end

  // Parameter index runs one ahead since the store has registered reads
  wire logic [4:0] pidx_next = (pos + 6'd1 >= 6'(RCF_POS_PARAM))
                               ? 5'(pos + 6'd1 - 6'(RCF_POS_PARAM)) : 5'd0;

  rcf_param_mem #(
    .DEPTH (PARAM_MAX)
  ) u_mem (
    .i_sys_clk (i_sys_clk),
    .i_we      (i_pw_en),
    .i_waddr   (i_pw_addr),
    .i_wdata   (i_pw_data),
    .i_raddr   (AW'(step ? pidx_next : pidx)),
    .o_rdata   (pbyte)
  );

  rcf_csum u_csum (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clear   (take),
    .i_add     (step && in_sum),
    .i_byte    (next_byte),
    .o_csum    (csum)
  );

  // ---------------------------------------------------------------
  // Sequencer; holds the presented byte steady while the host stalls
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= RCF_IDLE;
      req   <= '0;
      pos   <= 6'd0;
      pidx  <= 5'd0;
    end else begin
      case (state)
        RCF_IDLE: begin
          pos  <= 6'd0;
          pidx <= 5'd0;
          if (take && want_frame) begin
            req           <= i_req;
            req.param_len <= plen_eff;
            state         <= RCF_SEND;
          end
        end
        RCF_SEND: begin
          if (i_tx_ready) begin
            if (pos == last_pos) begin
              state <= RCF_IDLE;
            end else begin
              pos  <= pos + 6'd1;
              pidx <= pidx_next;
            end
          end
        end
        default: state <= RCF_IDLE;
      endcase
    end
  end

  // Combinational stream: presents the byte for position pos in the same cycle
  assign o_tx = '{valid: (state == RCF_SEND),
                  last:  (state == RCF_SEND) && (pos == last_pos),
                  data:  next_byte};

  // Pulse for a request that produced no frame
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dropped <= 1'b0;
    end else begin
      o_dropped <= take && !want_frame;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_frame_start;
    o_tx.valid && i_tx_ready && (pos == 6'd0);
  endsequence

  sequence s_stall;
    o_tx.valid && !i_tx_ready;
  endsequence

  sequence s_last_taken;
    o_tx.valid && o_tx.last && i_tx_ready;
  endsequence

  // A stalled host must see the same byte on the next edge
  property p_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
    s_stall |=> o_tx.valid && $stable(o_tx.data);
  endproperty
  a_hold: assert property (p_hold) else $error("byte changed while stalled");

  property p_last;
    @(posedge i_sys_clk) disable iff (i_rst)
    s_last_taken |=> !o_tx.valid && o_req_ready;
  endproperty
  a_last: assert property (p_last) else $error("frame did not end after checksum");

  property p_status;
    @(posedge i_sys_clk) disable iff (i_rst)
    o_tx.valid && pos == 6'd17 |-> o_tx.data == req.status;
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");

  property p_cmd_first;
    @(posedge i_sys_clk) disable iff (i_rst)
    o_tx.valid && pos == 6'd15 |-> o_tx.data == req.cmd[15:8];
  endproperty
  a_cmd_first: assert property (p_cmd_first) else $error("command order wrong");

  property p_delim;
    @(posedge i_sys_clk) disable iff (i_rst)
    s_frame_start |-> o_tx.data == 8'h7E;
  endproperty
  a_delim: assert property (p_delim) else $error("bad delimiter");

  property p_type;
    @(posedge i_sys_clk) disable iff (i_rst)
    o_tx.valid && pos == 6'd3 |-> o_tx.data == 8'h97;
  endproperty
  a_type: assert property (p_type) else $error("bad frame type");

  property p_zero_fid;
    @(posedge i_sys_clk) disable iff (i_rst)
    take && i_req.frame_id == 8'h00 |=> state == RCF_IDLE ##1 o_tx.valid == 1'b0;
  endproperty
  a_zero_fid: assert property (p_zero_fid) else $error("frame sent for zero id");

  property p_len_hi;
    @(posedge i_sys_clk) disable iff (i_rst)
    o_tx.valid && pos == 6'd1 |-> o_tx.data == 8'h00;
  endproperty
  a_len_hi: assert property (p_len_hi) else $error("length high byte wrong");

  property p_len_lo;
    @(posedge i_sys_clk) disable iff (i_rst)
    o_tx.valid && pos == 6'd2 |-> o_tx.data == 8'(8'd15 + {3'd0, req.param_len});
  endproperty
  a_len_lo: assert property (p_len_lo) else $error("length low byte wrong");

  property p_fid;
    @(posedge i_sys_clk) disable iff (i_rst)
    o_tx.valid && pos == 6'd4 |-> o_tx.data == req.frame_id && req.frame_id != 8'h00;
  endproperty
  a_fid: assert property (p_fid) else $error("frame id not echoed");

  property p_rsvd;
    @(posedge i_sys_clk) disable iff (i_rst)
    o_tx.valid && i_tx_ready && pos == 6'd13 |=> o_tx.data == 8'hFE;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved field wrong");

  property p_set_len;
    @(posedge i_sys_clk) disable iff (i_rst)
    take && want_frame && !i_req.is_query |=> last_pos == 6'd18;
  endproperty
  a_set_len: assert property (p_set_len) else $error("parameter sent after set");

  property p_addr_first;
    @(posedge i_sys_clk) disable iff (i_rst)
    o_tx.valid && pos == 6'd5 |-> o_tx.data == req.addr[63:56];
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("address order wrong");

endmodule

`default_nettype wire

//--- hdl/rcf_param_mem.sv
`timescale 1ns/1ps
`default_nettype none

// Parameter value store, written by the producer, read byte by byte
module rcf_param_mem
  import rcf_pkg::*;
#(
  parameter int DEPTH = RCF_PARAM_MAX
) (
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic      [7:0]               o_rdata
);

  logic [7:0] mem [DEPTH];

  // ---------------------------------------------------------------
  // Write port and registered read
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule

`default_nettype wire

//--- hdl/rcf_pkg.sv
package rcf_pkg;

  // ---------------------------------------------------------------
  // Frame constants
  // ---------------------------------------------------------------
  localparam logic [7:0]  RCF_DELIM      = 8'h7E;
  localparam logic [7:0]  RCF_TYPE_RESP  = 8'h97;
  localparam logic [7:0]  RCF_TYPE_REQ   = 8'h17;
  localparam logic [15:0] RCF_RESERVED   = 16'hFFFE;
  localparam logic [7:0]  RCF_CSUM_BASE  = 8'hFF;

  // Byte positions within the frame
  localparam int RCF_POS_DELIM  = 0;
  localparam int RCF_POS_LEN    = 1;
  localparam int RCF_POS_TYPE   = 3;
  localparam int RCF_POS_FID    = 4;
  localparam int RCF_POS_ADDR   = 5;
  localparam int RCF_POS_RSVD   = 13;
  localparam int RCF_POS_CMD    = 15;
  localparam int RCF_POS_STATUS = 17;
  localparam int RCF_POS_PARAM  = 18;

  // Fixed bytes counted by the length field: type through status
  localparam logic [15:0] RCF_LEN_FIXED = 16'h000F;

  // Largest parameter value carried, in bytes
  localparam int RCF_PARAM_MAX = 16;

  // Status codes
  localparam logic [7:0] RCF_ST_OK       = 8'h00;
  localparam logic [7:0] RCF_ST_ERROR    = 8'h01;
  localparam logic [7:0] RCF_ST_BAD_CMD  = 8'h02;
  localparam logic [7:0] RCF_ST_BAD_PARM = 8'h03;
  localparam logic [7:0] RCF_ST_TX_FAIL  = 8'h04;
  localparam logic [7:0] RCF_ST_CRYPT    = 8'h0C;

  // One handled request, as handed to the framer
  typedef struct packed {
    logic [7:0]  req_type;
    logic [7:0]  frame_id;
    logic [63:0] addr;
    logic [15:0] cmd;
    logic [7:0]  status;
    logic        is_query;
    logic [4:0]  param_len;
  } rcf_req_type;

  // Byte stream towards the host serial port
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } rcf_byte_type;

endpackage
